// ===== pwm_duty_phase_regs.sv
// Summary of operation
// - each generator has a 16-bit writable duty value, zero at reset, setting duty.
// - independent time base select low: phase register is phase shift for both outputs.
// - independent time base select high: phase register is the generator's own period.
// - output pair mode bits 11:10 pick complementary, redundant or push-pull.
//
// Purpose: register slice of one pwm generator with its duty and phase/period logic
// Assumes: APB slave, zero wait states, 32-bit data, 16-bit registers in low bits
// Notes:   master time base is local here; dead time and faults are out of scope
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pwm_duty_phase_defines.svh"
module pwm_duty_phase_regs #(
    parameter int WIDTH = 16
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             highSideOut,
    output logic             lowSideOut
);
    logic [WIDTH-1:0] dutyValue_reg;
    logic [WIDTH-1:0] phaseOrPeriod_reg;
    logic [15:0]      generatorControl_reg;
    logic [15:0]      outputControl_reg;
    logic [WIDTH-1:0] masterPeriod_reg;
    logic [31:0]      prdata_next;
    logic             highSide_next;
    logic             lowSide_next;
    logic             primaryActive;
    pwm_duty_phase_pkg::push_pull_state_e pushPull_reg;
    pwm_duty_phase_pkg::push_pull_state_e pushPull_next;
    logic [WIDTH-1:0] count;
    logic             wrap;

    wire setupRd     = psel && !penable && !pwrite;
    wire accessWr    = psel && penable && pwrite;
    wire selDuty     = (paddr == `DUTY_VALUE_OFS);
    wire selPhase    = (paddr == `PHASE_PERIOD_OFS);
    wire selGenCtl   = (paddr == `GEN_CONTROL_OFS);
    wire selOutCtl   = (paddr == `OUT_CONTROL_OFS);
    wire selStatus   = (paddr == `GEN_STATUS_OFS);
    wire mapped      = selDuty | selPhase | selGenCtl | selOutCtl | selStatus;
    // status is read-only; a write to it is refused like an unmapped one
    wire writeOk     = mapped && !selStatus;
    wire indepSel    = generatorControl_reg[`INDEP_SEL_BIT];
    wire generatorOn = generatorControl_reg[`PWM_EN_BIT];
    wire setupAny    = psel && !penable;
    // a refused transfer is flagged in its access phase and changes nothing
    wire refused     = pwrite ? !writeOk : !mapped;
    wire wrDuty      = clkEn && accessWr && selDuty;
    wire wrPhase     = clkEn && accessWr && selPhase;
    wire wrGenCtl    = clkEn && accessWr && selGenCtl;
    wire wrOutCtl    = clkEn && accessWr && selOutCtl;

    wire pushPullHigh = (pushPull_reg == pwm_duty_phase_pkg::PP_HIGH);
    wire pushPullLow  = (pushPull_reg == pwm_duty_phase_pkg::PP_LOW);

    wire pwm_duty_phase_pkg::output_pair_mode_e pairMode =
        pwm_duty_phase_pkg::output_pair_mode_e'(outputControl_reg[`PAIR_MODE_MSB:`PAIR_MODE_LSB]);

    // phase register is a period when independent, else a start offset on the master base
    wire [WIDTH-1:0] activePeriod = indepSel ? phaseOrPeriod_reg : masterPeriod_reg;
    wire [WIDTH-1:0] startOffset  = indepSel ? '0 : phaseOrPeriod_reg;

    // byte-lane mask for the 16-bit registers; lanes 2 and 3 never reach a register
    wire [15:0] laneMask;
    for (genvar lane = 0; lane < 2; lane++) begin : g_lane
        assign laneMask[8*lane +: 8] = {8{pstrb[lane]}};
    end

    // each merged word keeps the old byte wherever its strobe is low
    wire [15:0] dutyMerged   = (dutyValue_reg & ~laneMask) | (pwdata[15:0] & laneMask);
    wire [15:0] phaseMerged  = (phaseOrPeriod_reg & ~laneMask) | (pwdata[15:0] & laneMask);
    wire [15:0] genCtlMerged = (generatorControl_reg & ~laneMask) | (pwdata[15:0] & laneMask);
    wire [15:0] outCtlMerged = (outputControl_reg & ~laneMask) | (pwdata[15:0] & laneMask);

    pwm_timebase #(
        .WIDTH (WIDTH)
    ) u_timebase (
        .mclk       (mclk),
        .rstn       (rstn),
        .clkEn      (clkEn),
        .run        (generatorOn),
        .period     (activePeriod),
        .startCount (startOffset),
        .count      (count),
        .wrap       (wrap)
    );

    // strict compare makes duty of zero a 0% output and duty above period a 100% output
    assign primaryActive = generatorOn && (count < dutyValue_reg);

    always_comb begin
        highSide_next = 1'b0;
        lowSide_next  = 1'b0;
        case (pairMode)
            pwm_duty_phase_pkg::PAIR_COMPLEMENTARY: begin
                highSide_next = primaryActive;
                lowSide_next  = generatorOn && !primaryActive;
            end
            pwm_duty_phase_pkg::PAIR_REDUNDANT: begin
                highSide_next = primaryActive;
                lowSide_next  = primaryActive;
            end
            pwm_duty_phase_pkg::PAIR_PUSH_PULL: begin
                // alternate pins on each period so each sees every other pulse
                highSide_next = primaryActive && pushPullHigh;
                lowSide_next  = primaryActive && pushPullLow;
            end
            default: begin
                highSide_next = 1'b0;
                lowSide_next  = 1'b0;
            end
        endcase
    end

    always_comb begin
        prdata_next = 32'h0000_0000;
        case (1'b1)
            selDuty:   prdata_next[WIDTH-1:0] = dutyValue_reg;
            selPhase:  prdata_next[WIDTH-1:0] = phaseOrPeriod_reg;
            selGenCtl: prdata_next[15:0]      = generatorControl_reg;
            selOutCtl: prdata_next[15:0]      = outputControl_reg;
            selStatus: prdata_next[WIDTH-1:0] = count;
            default:   prdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dutyValue_reg <= `DUTY_RESET;
        end else if (wrDuty) begin
            dutyValue_reg <= dutyMerged;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phaseOrPeriod_reg <= `PHASE_RESET;
        end else if (wrPhase) begin
            phaseOrPeriod_reg <= phaseMerged;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            generatorControl_reg <= `GEN_CONTROL_RESET;
        end else if (wrGenCtl) begin
            generatorControl_reg <= genCtlMerged;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            outputControl_reg <= `OUT_CONTROL_RESET;
        end else if (wrOutCtl) begin
            outputControl_reg <= outCtlMerged;
        end
    end

    // master period is fixed here; the time base that runs on it is modelled inside this slice
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            masterPeriod_reg <= `MASTER_PERIOD_RESET;
        end else if (clkEn) begin
            masterPeriod_reg <= masterPeriod_reg;
        end
    end

    // push-pull steering flips at every period end; a stopped generator restarts on the high side
    always_comb begin
        pushPull_next = pushPull_reg;
        case (pushPull_reg)
            pwm_duty_phase_pkg::PP_HIGH: begin
                if (wrap) begin
                    pushPull_next = pwm_duty_phase_pkg::PP_LOW;
                end
            end
            pwm_duty_phase_pkg::PP_LOW: begin
                if (wrap) begin
                    pushPull_next = pwm_duty_phase_pkg::PP_HIGH;
                end
            end
            default: begin
                pushPull_next = pwm_duty_phase_pkg::PP_HIGH;
            end
        endcase
        if (!generatorOn) begin
            pushPull_next = pwm_duty_phase_pkg::PP_HIGH;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pushPull_reg <= pwm_duty_phase_pkg::PP_HIGH;
        end else if (clkEn) begin
            pushPull_reg <= pushPull_next;
        end
    end

    // zero-wait slave: ready in the access phase after a setup cycle with clkEn high
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= setupAny;
            pslverr <= setupAny && refused;
        end
    end

    // read data is captured in setup so it stands through the whole access phase
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (clkEn && setupRd) begin
            prdata <= prdata_next;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            highSideOut <= 1'b0;
            lowSideOut  <= 1'b0;
        end else if (clkEn) begin
            highSideOut <= highSide_next;
            lowSideOut  <= lowSide_next;
        end
    end
endmodule

// ===== pwm_duty_phase_defines.svh
// Purpose: offsets, field positions, reset values for the pwm duty/phase block
// Assumes: APB, one 32-bit aligned word per register
// Notes:   header holds definitions only
`ifndef PWM_DUTY_PHASE_DEFINES_SVH
`define PWM_DUTY_PHASE_DEFINES_SVH

`define DUTY_VALUE_OFS      12'h000
`define PHASE_PERIOD_OFS    12'h004
`define GEN_CONTROL_OFS     12'h008
`define OUT_CONTROL_OFS     12'h00C
`define GEN_STATUS_OFS      12'h010
`define INDEP_SEL_BIT       9
`define PAIR_MODE_LSB       10
`define PAIR_MODE_MSB       11
`define PWM_EN_BIT          15
`define DUTY_RESET          16'h0000
`define PHASE_RESET         16'h0000
`define GEN_CONTROL_RESET   16'h0000
`define OUT_CONTROL_RESET   16'h0000
`define MASTER_PERIOD_RESET 16'hFFFF

`endif

// ===== pwm_duty_phase_pkg.sv
// Purpose: types shared by the pwm duty/phase block
// Assumes: nothing
// Notes:   offsets and values live in the defines header
package pwm_duty_phase_pkg;
    typedef enum logic [1:0] {
        PAIR_COMPLEMENTARY = 2'h0,
        PAIR_REDUNDANT     = 2'h1,
        PAIR_PUSH_PULL     = 2'h2,
        PAIR_RESERVED      = 2'h3
    } output_pair_mode_e;

    typedef enum logic [1:0] {
        PP_HIGH = 2'b01,
        PP_LOW  = 2'b10
    } push_pull_state_e;
endpackage

// ===== pwm_timebase.sv
// Purpose: time-base counter with wrap at the selected period
// Assumes: period of zero is treated as a one-count period
// Notes:   count rests on the start offset (zero if that is at or past the period) while the generator is off
`timescale 1ns/1ps
module pwm_timebase #(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             clkEn,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] period,
    input  wire logic [WIDTH-1:0] startCount,
    output logic      [WIDTH-1:0] count,
    output logic                  wrap
);
    logic [WIDTH-1:0] count_next;
    wire              atEnd     = (count >= period);
    // an offset at or past the period would wrap at once, so it starts from zero instead
    wire  [WIDTH-1:0] idleCount = (startCount >= period) ? '0 : startCount;

    assign wrap = run && atEnd;

    always_comb begin
        if (atEnd) begin
            count_next = '0;
        end else begin
            count_next = count + 1'b1;
        end
    end

    // resting on the offset means the first enabled cycle already compares the phase,
    // so no stray pulse from a zero count appears at start-up
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (clkEn) begin
            if (run) begin
                count <= count_next;
            end else begin
                count <= idleCount;
            end
        end
    end
endmodule

// ===== pwm_duty_phase_props.sv
// Purpose: concurrent checks on the pwm duty/phase register block ports
// Assumes: shadow copies follow accepted writes lane by lane
// Notes:   outputs judged only once settings have stood three cycles
`timescale 1ns/1ps
module pwm_duty_phase_props (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        clkEn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        highSideOut,
    input wire logic        lowSideOut
);
    logic [15:0] dutyS;
    logic        onS;
    logic [1:0]  mdS;
    logic [1:0]  settle;
    wire         wrOk = psel && penable && pwrite && pready && !pslverr;
    // any accepted write restarts the settle count, so outputs are not judged mid-change
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dutyS <= 16'h0000;
            onS <= 1'b0;
            mdS <= 2'h0;
            settle <= 2'h0;
        end else if (wrOk) begin
            settle <= 2'h0;
            if (paddr == 12'h000) begin
                dutyS[15:8] <= pstrb[1] ? pwdata[15:8] : dutyS[15:8];
                dutyS[7:0]  <= pstrb[0] ? pwdata[7:0] : dutyS[7:0];
            end
            if (paddr == 12'h008 && pstrb[1]) onS <= pwdata[15];
            if (paddr == 12'h00C && pstrb[1]) mdS <= pwdata[11:10];
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire ok = settle == 2'h3;
    property p_ready; psel && !penable && clkEn |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_zero; ok && dutyS == 16'h0000 |-> !highSideOut; endproperty
    a_zero: assert property (p_zero) else $error("output active at zero duty");
    property p_off; ok && !onS |-> !highSideOut && !lowSideOut; endproperty
    a_off: assert property (p_off) else $error("output active while disabled");
    property p_compl; ok && onS && mdS == 2'h0 |-> lowSideOut != highSideOut; endproperty
    a_compl: assert property (p_compl) else $error("complementary pair equal");
    property p_redun; ok && onS && mdS == 2'h1 |-> lowSideOut == highSideOut; endproperty
    a_redun: assert property (p_redun) else $error("redundant pair differs");
    property p_push; ok && mdS == 2'h2 |-> !(highSideOut && lowSideOut); endproperty
    a_push: assert property (p_push) else $error("push-pull both active");
    property p_rsvd; ok && mdS == 2'h3 |-> !highSideOut && !lowSideOut; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode drives output");
    cover property (ok && onS && mdS == 2'h2 && lowSideOut);
    cover property (pready && pslverr);
    cover property (wrOk && paddr == 12'h000);
endmodule
bind pwm_duty_phase_regs pwm_duty_phase_props u_props (
    .mclk(mclk), .rstn(rstn), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .highSideOut(highSideOut), .lowSideOut(lowSideOut)
);

// ===== tb_top.sv
// Purpose: self-checking bench for the pwm duty/phase register block
// Assumes: APB slave; full-word strobes except one partial write
// Notes:   output pattern is counted over whole periods, so phase of sampling is free
`timescale 1ns/1ps
module tb_top;
    logic        mclk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        highSideOut;
    logic        lowSideOut;
    logic [31:0] rd;
    logic        er;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    pwm_duty_phase_regs dut (
        .mclk(mclk), .rstn(rstn), .clkEn(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .highSideOut(highSideOut), .lowSideOut(lowSideOut)
    );
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard well above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            fail_count++;
            $display("Error %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge keeps back-to-back calls from driving psel twice in one step
        @(posedge mclk);
    endtask
    initial begin
        int hits;
        int exp [4];
        exp = '{12, 8, 4, 0};
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            chk({31'h0, er}, 32'h0000_0000);
        end
        apb(1'b1, 12'h000, 32'hFFFF_A5C3);
        apb(1'b1, 12'h004, 32'h0000_5A3C);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_A5C3);
        pstrb <= 4'h2;
        apb(1'b1, 12'h000, 32'h0000_7E00);
        pstrb <= 4'hF;
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_7EC3);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_5A3C);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_1234);
        chk({31'h0, er}, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_0002);
        apb(1'b1, 12'h004, 32'h0000_0005);
        apb(1'b1, 12'h008, 32'h0000_8200);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 12'h00C, 32'(m) << 10);
            repeat (20) @(posedge mclk);
            hits = 0;
            repeat (12) begin
                @(posedge mclk);
                #1 hits += int'(highSideOut) + int'(lowSideOut);
            end
            @(posedge mclk);
            chk(32'(hits), 32'(exp[m]));
        end
        apb(1'b1, 12'h00C, 32'h0000_0000);
        apb(1'b1, 12'h008, 32'h0000_0000);
        apb(1'b1, 12'h004, 32'h0000_1000);
        apb(1'b1, 12'h008, 32'h0000_8000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        // the running count starts from the written phase
        chk({31'h0, rd >= 32'h0000_1000 && rd <= 32'h0000_1010}, 32'h0000_0001);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk({30'h0, highSideOut, lowSideOut}, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        print_verdict();
    end
endmodule
